// File: src/sei_dev.sv
`timescale 1ns/1ps
module sei_dev import sei_pkg::*; #(
  parameter int unsigned P_PROG_CYCLES = SEI_PROG_CYCLES
) (
  // Serial link.
  sei_if.dev lnk,
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Status.
  output logic o_busy,
  output logic o_prog_enabled
);
  typedef enum {D_IDLE, D_CMD, D_DATA, D_READ, D_ARMED, D_PROG} sei_dstate_t;

  // Storage array, kept without reset as it models nonvolatile cells.
  logic [SEI_DATA_W-1:0] mem_ff [SEI_WORDS];

  logic [3:0] meta_ff, sync_ff;
  logic sk_d_ff;
  sei_dstate_t state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [SEI_CMD_BITS-1:0] cmd_ff, nxt_cmd;
  logic [SEI_DATA_W-1:0] data_ff, nxt_data;
  logic [SEI_DATA_W:0] rd_ff, nxt_rd;
  logic [SEI_PROG_W-1:0] tmr_ff, nxt_tmr;
  logic en_ff, nxt_en;
  logic pe_ok_ff, nxt_pe_ok;
  logic stat_ff, nxt_stat;
  logic do_ff, nxt_do;
  logic do_oe_ff, nxt_do_oe;
  logic mem_we;

  logic cs_s, sk_s, di_s, pe_s, rise;
  logic [SEI_CMD_BITS-1:0] cmd_full;
  logic [1:0] opc, top;
  logic [SEI_ADDR_W-1:0] adr;

  assign cs_s = sync_ff[SEI_SYN_CS];
  assign sk_s = sync_ff[SEI_SYN_SK];
  assign di_s = sync_ff[SEI_SYN_DI];
  assign pe_s = sync_ff[SEI_SYN_PE];
  assign rise = sk_s & ~sk_d_ff;
  assign cmd_full = {cmd_ff[SEI_CMD_BITS-2:0], di_s};
  assign opc = cmd_ff[SEI_CMD_BITS-1 -: 2];
  assign top = cmd_ff[SEI_ADDR_W-1 -: 2];
  assign adr = cmd_ff[SEI_ADDR_W-1:0];

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cmd = cmd_ff;
    nxt_data = data_ff;
    nxt_rd = rd_ff;
    nxt_tmr = tmr_ff;
    nxt_en = en_ff;
    nxt_pe_ok = pe_ok_ff;
    nxt_stat = stat_ff;
    mem_we = 1'b0;
    case (state_ff)
      D_IDLE: begin
        // Zeros ahead of the start bit are skipped.
        if (cs_s && rise && di_s) begin
          nxt_state = D_CMD;
          nxt_cnt = '0;
          nxt_pe_ok = pe_s;
          nxt_stat = 1'b0;
        end
      end
      D_CMD: begin
        nxt_pe_ok = pe_ok_ff & pe_s;
        if (!cs_s) begin
          nxt_state = D_IDLE;
        end else if (rise) begin
          nxt_cmd = cmd_full;
          nxt_cnt = cnt_ff + 1'b1;
          if (cnt_ff == SEI_CMD_LAST) begin
            nxt_cnt = '0;
            case (cmd_full[SEI_CMD_BITS-1 -: 2])
              SEI_OPC_READ: begin
                nxt_rd = {1'b0, mem_ff[cmd_full[SEI_ADDR_W-1:0]]};
                nxt_state = D_READ;
              end
              SEI_OPC_WRITE: nxt_state = D_DATA;
              SEI_OPC_ERASE: nxt_state = D_ARMED;
              default: begin
                // Low four address bits are don't-care here.
                case (cmd_full[SEI_ADDR_W-1 -: 2])
                  SEI_EXT_FILL: nxt_state = D_DATA;
                  SEI_EXT_EN: begin
                    nxt_en = nxt_en | (pe_ok_ff & pe_s);
                    nxt_state = D_ARMED;
                  end
                  SEI_EXT_DIS: begin
                    nxt_en = nxt_en & ~(pe_ok_ff & pe_s);
                    nxt_state = D_ARMED;
                  end
                  default: nxt_state = D_ARMED;
                endcase
              end
            endcase
          end
        end
      end
      D_DATA: begin
        nxt_pe_ok = pe_ok_ff & pe_s;
        if (!cs_s) begin
          nxt_state = D_IDLE;
        end else if (rise) begin
          nxt_data = {data_ff[SEI_DATA_W-2:0], di_s};
          nxt_cnt = cnt_ff + 1'b1;
          if (cnt_ff == SEI_DATA_LAST) begin
            nxt_state = D_ARMED;
          end
        end
      end
      D_READ: begin
        if (!cs_s) begin
          nxt_state = D_IDLE;
        end else if (rise) begin
          nxt_rd = {rd_ff[SEI_DATA_W-1:0], 1'b0};
        end
      end
      D_ARMED: begin
        // Clocks after a complete frame are ignored until deselect.
        if (!cs_s) begin
          if (sei_is_prog(opc, top) && en_ff && pe_ok_ff) begin
            nxt_tmr = SEI_PROG_W'(P_PROG_CYCLES - 1);
            nxt_stat = 1'b1;
            nxt_state = D_PROG;
          end else begin
            nxt_state = D_IDLE;
          end
        end
      end
      D_PROG: begin
        // Counts on the system clock only, so no serial edges are needed.
        nxt_tmr = tmr_ff - 1'b1;
        if (tmr_ff == '0) begin
          mem_we = 1'b1;
          nxt_state = D_IDLE;
        end
      end
      default: nxt_state = D_IDLE;
    endcase
  end

  // The data output only drives for read data or for status once a programming cycle has started.
  always_comb begin
    nxt_do_oe = cs_s && ((state_ff == D_READ) ||
                         (stat_ff && ((state_ff == D_IDLE) || (state_ff == D_PROG))));
    nxt_do = (state_ff == D_READ) ? rd_ff[SEI_DATA_W] : (state_ff != D_PROG);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
      sk_d_ff <= 1'b0;
    end else begin
      meta_ff <= {lnk.pe_lvl, lnk.di, lnk.sk, lnk.cs};
      sync_ff <= meta_ff;
      sk_d_ff <= sk_s;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= D_IDLE;
      cnt_ff <= '0;
      cmd_ff <= '0;
      data_ff <= '0;
      rd_ff <= '0;
      tmr_ff <= '0;
      en_ff <= 1'b0;
      pe_ok_ff <= 1'b0;
      stat_ff <= 1'b0;
      do_ff <= 1'b0;
      do_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cmd_ff <= nxt_cmd;
      data_ff <= nxt_data;
      rd_ff <= nxt_rd;
      tmr_ff <= nxt_tmr;
      en_ff <= nxt_en;
      pe_ok_ff <= nxt_pe_ok;
      stat_ff <= nxt_stat;
      do_ff <= nxt_do;
      do_oe_ff <= nxt_do_oe;
    end
  end

  // Array update lands at the end of the timed cycle.
  always_ff @(posedge i_mclk) begin
    if (mem_we) begin
      case (opc)
        SEI_OPC_WRITE: mem_ff[adr] <= mem_ff[adr] & data_ff;
        SEI_OPC_ERASE: mem_ff[adr] <= '1;
        default: begin
          for (int i = 0; i < SEI_WORDS; i++) begin
            mem_ff[i] <= (top == SEI_EXT_FILL) ? data_ff : '1;
          end
        end
      endcase
    end
  end

  assign lnk.do_o = do_ff;
  assign lnk.do_oe = do_oe_ff;
  assign o_busy = state_ff == D_PROG;
  assign o_prog_enabled = en_ff;
endmodule // sei_dev

// File: src/sei_fifo.sv
`timescale 1ns/1ps
module sei_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Fill side.
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side.
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic push, pop;

  assign o_in_ready = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
  assign o_out_valid = wp_ff != rp_ff;
  assign o_out_data = mem_ff[rp_ff[AW-1:0]];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_comb begin
    nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_ff[wp_ff[AW-1:0]] <= i_in_data;
    end
  end
endmodule // sei_fifo

// File: src/sei_host.sv
`timescale 1ns/1ps
module sei_host import sei_pkg::*; #(
  // Serial clock half period in system clocks; a test may shorten it to keep runs brief.
  parameter logic [SEI_TMR_W-1:0] P_SK_HALF_CYC = SEI_SK_HALF_CYC
) (
  // Serial link.
  sei_if.host lnk,
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Command queue.
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire sei_cmd_t i_cmd,
  input wire logic i_pe_level,
  // Results.
  output logic o_rd_valid,
  output logic [SEI_DATA_W-1:0] o_rd_data,
  output logic o_done
);
  typedef enum {H_IDLE, H_SHIFT, H_READ, H_GAP, H_POLL} sei_hstate_t;

  sei_hstate_t state_ff, nxt_state;
  logic [SEI_FRAME_W-1:0] tx_ff, nxt_tx;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [SEI_DATA_W-1:0] rx_ff, nxt_rx;
  logic [SEI_TMR_W-1:0] div_ff, nxt_div, tmr_ff, nxt_tmr;
  logic cs_ff, nxt_cs, sk_ff, nxt_sk, di_ff, nxt_di, pe_ff;
  logic poll_ff, nxt_poll, rdop_ff, nxt_rdop, rdv_ff, nxt_rdv, done_ff, nxt_done;
  logic do_meta_ff, do_sync_ff;
  logic f_valid, f_pop, tick;
  sei_cmd_t f_cmd;
  logic [SEI_FRAME_W-1:0] frame;

  sei_fifo #(.W($bits(sei_cmd_t)), .DEPTH(SEI_FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_cmd_valid),
    .o_in_ready(o_cmd_ready),
    .i_in_data(i_cmd),
    .o_out_valid(f_valid),
    .i_out_ready(f_pop),
    .o_out_data(f_cmd)
  );

  assign tick = div_ff == P_SK_HALF_CYC - 1'b1;
  assign frame = sei_frame(f_cmd);

  always_comb begin
    nxt_state = state_ff;
    nxt_tx = tx_ff;
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_div = tick ? '0 : div_ff + 1'b1;
    nxt_tmr = tmr_ff;
    nxt_cs = cs_ff;
    nxt_sk = sk_ff;
    nxt_di = di_ff;
    nxt_poll = poll_ff;
    nxt_rdop = rdop_ff;
    nxt_rdv = 1'b0;
    nxt_done = 1'b0;
    f_pop = 1'b0;
    case (state_ff)
      H_IDLE: begin
        if (f_valid) begin
          f_pop = 1'b1;
          nxt_tx = frame;
          nxt_di = frame[SEI_FRAME_W-1];
          nxt_cnt = ((f_cmd.op == SEI_OP_WRITE) || (f_cmd.op == SEI_OP_FILL)) ?
                    SEI_CMD_LAST + 5'(SEI_DATA_W) + 5'h01 : SEI_CMD_LAST + 5'h01;
          nxt_rdop = f_cmd.op == SEI_OP_READ;
          nxt_poll = sei_is_prog(frame[SEI_FRAME_W-2 -: 2], frame[SEI_DATA_W+SEI_ADDR_W-1 -: 2]);
          nxt_cs = 1'b1;
          nxt_div = '0;
          nxt_state = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (tick) begin
          nxt_sk = ~sk_ff;
          if (sk_ff) begin
            nxt_tx = tx_ff << 1;
            nxt_di = tx_ff[SEI_FRAME_W-2];
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == '0) begin
              nxt_cnt = SEI_DATA_LAST;
              nxt_cs = rdop_ff;
              nxt_tmr = SEI_DESEL_CYC - 1'b1;
              nxt_state = rdop_ff ? H_READ : H_GAP;
            end
          end
        end
      end
      H_READ: begin
        if (tick) begin
          nxt_sk = ~sk_ff;
          if (sk_ff) begin
            nxt_rx = {rx_ff[SEI_DATA_W-2:0], do_sync_ff};
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == '0) begin
              nxt_cs = 1'b0;
              nxt_rdv = 1'b1;
              nxt_tmr = SEI_DESEL_CYC - 1'b1;
              nxt_state = H_GAP;
            end
          end
        end
      end
      H_GAP: begin
        nxt_tmr = tmr_ff - 1'b1;
        if (tmr_ff == '0) begin
          nxt_tmr = SEI_STATUS_CYC - 1'b1;
          nxt_cs = poll_ff;
          nxt_done = ~poll_ff;
          nxt_state = poll_ff ? H_POLL : H_IDLE;
        end
      end
      H_POLL: begin
        if (tmr_ff != '0) begin
          nxt_tmr = tmr_ff - 1'b1;
        end else if (do_sync_ff) begin
          nxt_cs = 1'b0;
          nxt_poll = 1'b0;
          nxt_tmr = SEI_DESEL_CYC - 1'b1;
          nxt_state = H_GAP;
        end
      end
      default: nxt_state = H_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= H_IDLE;
      tx_ff <= '0;
      cnt_ff <= '0;
      rx_ff <= '0;
      div_ff <= '0;
      tmr_ff <= '0;
      cs_ff <= 1'b0;
      sk_ff <= 1'b0;
      di_ff <= 1'b0;
      pe_ff <= 1'b1;
      poll_ff <= 1'b0;
      rdop_ff <= 1'b0;
      rdv_ff <= 1'b0;
      done_ff <= 1'b0;
      do_meta_ff <= 1'b1;
      do_sync_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      tx_ff <= nxt_tx;
      cnt_ff <= nxt_cnt;
      rx_ff <= nxt_rx;
      div_ff <= nxt_div;
      tmr_ff <= nxt_tmr;
      cs_ff <= nxt_cs;
      sk_ff <= nxt_sk;
      di_ff <= nxt_di;
      pe_ff <= i_pe_level;
      poll_ff <= nxt_poll;
      rdop_ff <= nxt_rdop;
      rdv_ff <= nxt_rdv;
      done_ff <= nxt_done;
      do_meta_ff <= lnk.do_lvl;
      do_sync_ff <= do_meta_ff;
    end
  end

  assign lnk.cs = cs_ff;
  assign lnk.sk = sk_ff;
  assign lnk.di = di_ff;
  assign lnk.pe_o = pe_ff;
  // High is left to the pin's pull-up, so the host only ever drives the enable pin low.
  assign lnk.pe_oe = ~pe_ff;
  assign o_rd_valid = rdv_ff;
  assign o_rd_data = rx_ff;
  assign o_done = done_ff;
endmodule // sei_host

// File: src/sei_if.sv
`timescale 1ns/1ps
interface sei_if;
  logic cs;
  logic sk;
  logic di;
  logic pe_o;
  logic pe_oe;
  logic do_o;
  logic do_oe;
  logic pe_lvl;
  logic do_lvl;

  // An undriven enable pin reads high through its pull-up.
  assign pe_lvl = pe_oe ? pe_o : 1'b1;
  // A released data output is seen high by the host.
  assign do_lvl = do_oe ? do_o : 1'b1;

  modport dev(input cs, input sk, input di, input pe_lvl, output do_o, output do_oe);
  modport host(output cs, output sk, output di, output pe_o, output pe_oe, input do_lvl);
endinterface

// File: src/sei_pkg.sv
// How it works
// - Array holds 64 words of 16 bits.
// - Frame is start bit, opcode, six-bit address.
// - Opcode 10 read, 01 write, 11 erase.
// - Opcode 00 uses top address bits as function.
// - Fill command programs 16-bit pattern everywhere.
// - Erase-everything command sets whole array to ones.
// - Chip select fall starts programming cycle.
// - Programming finishes without further serial clocks.
// - Host keeps select low at least 1 us.
// - Programming cycle lasts at most 10 ms.
// - Selected output low while busy, high ready.
// - Output released except read or status polling.
// - Input bits sampled on serial clock rise.
// - Host polls ready status instead of waiting.
// - Disabled state refuses all programming commands.
// - Hardware enable must stay high while shifting.
// - Hardware enable input pulls up when unconnected.
// - Read sends zero dummy then 16 bits.
// - Programming starts disabled after reset.
// - Erase sets ones, write only clears bits.
// - Host drops select after last data bit.
package sei_pkg;

  localparam int SEI_WORDS = 64;
  localparam int SEI_DATA_W = 16;
  localparam int SEI_ADDR_W = 6;
  localparam int SEI_CMD_BITS = 8;
  localparam int SEI_FIFO_DEPTH = 16;

  localparam logic [1:0] SEI_OPC_EXT = 2'h0;
  localparam logic [1:0] SEI_OPC_WRITE = 2'h1;
  localparam logic [1:0] SEI_OPC_READ = 2'h2;
  localparam logic [1:0] SEI_OPC_ERASE = 2'h3;
  localparam logic [1:0] SEI_EXT_DIS = 2'h0;
  localparam logic [1:0] SEI_EXT_FILL = 2'h1;
  localparam logic [1:0] SEI_EXT_ERALL = 2'h2;
  localparam logic [1:0] SEI_EXT_EN = 2'h3;

  localparam int SEI_SYN_CS = 0;
  localparam int SEI_SYN_SK = 1;
  localparam int SEI_SYN_DI = 2;
  localparam int SEI_SYN_PE = 3;

  localparam int SEI_CLK_MHZ = 200;
  localparam int SEI_PROG_TIME_MS = 10;
  localparam int SEI_PROG_CYCLES = SEI_PROG_TIME_MS * 1000 * SEI_CLK_MHZ;
  localparam int SEI_PROG_W = 21;
  localparam int SEI_SK_HALF_NS = 2000;
  localparam int SEI_DESEL_NS = 1000;
  localparam int SEI_STATUS_NS = 1000;
  localparam int SEI_TMR_W = 9;
  localparam logic [SEI_TMR_W-1:0] SEI_SK_HALF_CYC = SEI_TMR_W'(SEI_SK_HALF_NS * SEI_CLK_MHZ / 1000);
  localparam logic [SEI_TMR_W-1:0] SEI_DESEL_CYC = SEI_TMR_W'((SEI_DESEL_NS * SEI_CLK_MHZ + 999) / 1000);
  localparam logic [SEI_TMR_W-1:0] SEI_STATUS_CYC = SEI_TMR_W'((SEI_STATUS_NS * SEI_CLK_MHZ + 999) / 1000);

  localparam logic [4:0] SEI_CMD_LAST = 5'(SEI_CMD_BITS - 1);
  localparam logic [4:0] SEI_DATA_LAST = 5'(SEI_DATA_W - 1);
  localparam int SEI_FRAME_W = 1 + SEI_CMD_BITS + SEI_DATA_W;

  typedef enum logic [2:0] {
    SEI_OP_READ, SEI_OP_WRITE, SEI_OP_ERASE, SEI_OP_EN, SEI_OP_DIS, SEI_OP_ERALL, SEI_OP_FILL
  } sei_op_t;

  typedef struct packed {
    sei_op_t op;
    logic [SEI_ADDR_W-1:0] addr;
    logic [SEI_DATA_W-1:0] data;
  } sei_cmd_t;

  // Left-aligned frame: start bit, opcode, address, then data where the command carries it.
  function automatic logic [SEI_FRAME_W-1:0] sei_frame(input sei_cmd_t c);
    logic [1:0] opc;
    logic [SEI_ADDR_W-1:0] a;
    opc = SEI_OPC_EXT;
    a = c.addr;
    case (c.op)
      SEI_OP_READ: opc = SEI_OPC_READ;
      SEI_OP_WRITE: opc = SEI_OPC_WRITE;
      SEI_OP_ERASE: opc = SEI_OPC_ERASE;
      SEI_OP_EN: a = {SEI_EXT_EN, 4'h0};
      SEI_OP_DIS: a = {SEI_EXT_DIS, 4'h0};
      SEI_OP_ERALL: a = {SEI_EXT_ERALL, 4'h0};
      default: a = {SEI_EXT_FILL, 4'h0};
    endcase
    return {1'b1, opc, a, c.data};
  endfunction

  function automatic logic sei_is_prog(input logic [1:0] opc, input logic [1:0] top);
    return (opc == SEI_OPC_WRITE) || (opc == SEI_OPC_ERASE) ||
           ((opc == SEI_OPC_EXT) && ((top == SEI_EXT_ERALL) || (top == SEI_EXT_FILL)));
  endfunction

endpackage

// File: test/sei_checker.sv
`timescale 1ns/1ps
module sei_checker #(
  parameter int unsigned P_PROG_CYCLES = 50
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Link signals.
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic pe_oe,
  input wire logic pe_lvl,
  input wire logic do_o,
  input wire logic do_oe
);
  logic sk_q_ff;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [2:0] hdr_ff, nxt_hdr;
  logic [8:0] csl_ff, nxt_csl;
  logic [31:0] low_ff, nxt_low;
  logic rise;
  logic rd9;
  logic start;

  assign rise = cs && sk && !sk_q_ff;
  assign rd9 = cs && (cnt_ff == 5'h9) && (hdr_ff == 3'h6);
  assign start = rise && (cnt_ff == 5'h0) && di;

  // Counts rises per frame, keeps the first three bits and times the deselect gap.
  always_comb begin
    nxt_cnt = cs ? cnt_ff + 5'(rise) : 5'h0;
    nxt_hdr = (rise && cnt_ff < 5'h3) ? {hdr_ff[1:0], di} : hdr_ff;
    nxt_csl = cs ? 9'h0 : csl_ff + 9'(csl_ff != 9'h1ff);
    nxt_low = (cs && cnt_ff == 5'h0 && do_oe && !do_o) ? low_ff + 32'h1 : 32'h0;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sk_q_ff <= 1'b0;
      cnt_ff <= 5'h0;
      hdr_ff <= 3'h0;
      csl_ff <= 9'h1ff;
      low_ff <= 32'h0;
    end else begin
      sk_q_ff <= sk;
      cnt_ff <= nxt_cnt;
      hdr_ff <= nxt_hdr;
      csl_ff <= nxt_csl;
      low_ff <= nxt_low;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  property p_dummy_zero;
    $rose(rd9) |-> ##[1:6] (do_oe && !do_o);
  endproperty
  property p_release_unsel;
    !cs [*8] |-> !do_oe;
  endproperty
  property p_drive_selected;
    $rose(do_oe) |-> cs;
  endproperty
  property p_release_start;
    start |-> ##[1:6] !do_oe;
  endproperty
  property p_status_mono;
    (cs && cnt_ff == 5'h0 && do_oe && do_o) |=> (!cs || !do_oe || do_o || cnt_ff != 5'h0);
  endproperty
  property p_cycle_bound;
    low_ff <= P_PROG_CYCLES;
  endproperty
  property p_frame_len;
    $fell(cs) |-> (cnt_ff == 5'h0 || cnt_ff == 5'h9 || cnt_ff == 5'h19);
  endproperty
  property p_desel_min;
    $rose(cs) |-> csl_ff >= 9'h0c8;
  endproperty
  property p_sk_idle;
    !cs |-> !sk;
  endproperty
  property p_pe_pullup;
    !pe_oe |-> pe_lvl;
  endproperty

  a_dummy_zero: assert property (p_dummy_zero) else $error("read dummy bit not low");
  a_release_unsel: assert property (p_release_unsel) else $error("data out driven while deselected");
  a_drive_selected: assert property (p_drive_selected) else $error("data out enabled without select");
  a_release_start: assert property (p_release_start) else $error("data out kept at start bit");
  a_status_mono: assert property (p_status_mono) else $error("ready status fell back");
  a_cycle_bound: assert property (p_cycle_bound) else $error("busy status too long");
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  a_desel_min: assert property (p_desel_min) else $error("deselect gap too short");
  a_sk_idle: assert property (p_sk_idle) else $error("serial clock moves while deselected");
  a_pe_pullup: assert property (p_pe_pullup) else $error("enable pin not pulled up");

  c_read: cover property ($rose(rd9));
  c_ready: cover property (cs && cnt_ff == 5'h0 && do_oe && do_o);
  c_long_frame: cover property ($fell(cs) && cnt_ff == 5'h19);
endmodule // sei_checker

// File: test/serial_eeprom_command_interface_bench.sv
`timescale 1ns/1ps
module serial_eeprom_command_interface_bench import sei_pkg::*;;
  localparam int PROG = 50;
  logic mclk, rst_n, cmd_valid, cmd_ready, pe_level, rd_valid, done, busy, prog_en;
  logic [15:0] rd_data;
  sei_cmd_t cmd;
  sei_cmd_t q[$];
  logic [15:0] rd_q[$];
  int n_mismatch, compares, ndone, span;

  sei_if lnk();
  sei_host #(.P_SK_HALF_CYC(SEI_TMR_W'(20))) u_sei_host(.lnk(lnk), .i_mclk(mclk), .i_rst_n(rst_n),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd(cmd), .i_pe_level(pe_level), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_done(done));
  sei_dev #(.P_PROG_CYCLES(PROG)) u_sei_dev(.lnk(lnk), .i_mclk(mclk), .i_rst_n(rst_n),
    .o_busy(busy), .o_prog_enabled(prog_en));
  sei_checker #(.P_PROG_CYCLES(PROG)) u_sei_checker(.i_mclk(mclk), .i_rst_n(rst_n), .cs(lnk.cs),
    .sk(lnk.sk), .di(lnk.di), .pe_oe(lnk.pe_oe), .pe_lvl(lnk.pe_lvl), .do_o(lnk.do_o),
    .do_oe(lnk.do_oe));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task print_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Collects read words and completions, and measures every busy span.
  always @(negedge mclk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (done === 1'b1) ndone++;
    if (busy === 1'b1) begin
      span++;
    end else if (span != 0) begin
      check("busy span", span, PROG);
      span = 0;
    end
  end

  // Pushes all queued commands back to back, then waits until each has completed.
  task run();
    int n, k;
    n = q.size();
    ndone = 0;
    k = 0;
    foreach (q[i]) begin
      cmd_valid <= 1'b1;
      cmd <= q[i];
      @(posedge mclk);
    end
    cmd_valid <= 1'b0;
    q.delete();
    @(negedge mclk);
    check("command queue ready", cmd_ready, n <= SEI_FIFO_DEPTH);
    while (ndone < n && k < 20000) begin
      @(negedge mclk);
      k++;
    end
    check("commands done", ndone, n);
    @(posedge mclk);
  endtask

  // Seventeen commands back to back leave the queue full; the reads show they ran in order.
  task fifo_test();
    q.push_back('{SEI_OP_EN, 6'h00, 16'h0000});
    q.push_back('{SEI_OP_ERASE, 6'h02, 16'h0000});
    q.push_back('{SEI_OP_WRITE, 6'h02, 16'h5a5a});
    q.push_back('{SEI_OP_READ, 6'h02, 16'h0000});
    repeat (11) q.push_back('{SEI_OP_DIS, 6'h00, 16'h0000});
    q.push_back('{SEI_OP_ERASE, 6'h02, 16'h0000});
    q.push_back('{SEI_OP_READ, 6'h02, 16'h0000});
    run();
    check("reads returned", rd_q.size(), 2);
    check("read word 2", rd_q.pop_front(), 16'h5a5a);
    check("read word 2", rd_q.pop_front(), 16'h5a5a);
    check("prog enabled", prog_en, 0);
    $display("test fifo done");
  endtask

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    pe_level = 1'b1;
    n_mismatch = 0;
    compares = 0;
    ndone = 0;
    span = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check("prog enabled", prog_en, 0);
    check("data out enable", lnk.do_oe, 0);
    $display("test reset done");
    @(posedge mclk);
    pe_level <= 1'b0;
    q.push_back('{SEI_OP_EN, 6'h00, 16'h0000});
    run();
    check("prog enabled", prog_en, 0);
    pe_level <= 1'b1;
    q.push_back('{SEI_OP_EN, 6'h00, 16'h0000});
    run();
    check("prog enabled", prog_en, 1);
    $display("test enable done");
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check("prog enabled", prog_en, 0);
    check("command queue ready", cmd_ready, 1);
    $display("test restart done");
    @(posedge mclk);
    q.push_back('{SEI_OP_EN, 6'h00, 16'h0000});
    q.push_back('{SEI_OP_FILL, 6'h00, 16'h1234});
    q.push_back('{SEI_OP_ERASE, 6'h05, 16'h0000});
    q.push_back('{SEI_OP_READ, 6'h05, 16'h0000});
    q.push_back('{SEI_OP_WRITE, 6'h3f, 16'hff0f});
    q.push_back('{SEI_OP_READ, 6'h3f, 16'h0000});
    run();
    check("reads returned", rd_q.size(), 2);
    check("read word 5", rd_q.pop_front(), 16'hffff);
    check("read word 63", rd_q.pop_front(), 16'h1204);
    $display("test program done");
    q.push_back('{SEI_OP_DIS, 6'h00, 16'h0000});
    q.push_back('{SEI_OP_ERALL, 6'h00, 16'h0000});
    q.push_back('{SEI_OP_READ, 6'h3f, 16'h0000});
    run();
    check("prog enabled", prog_en, 0);
    check("reads returned", rd_q.size(), 1);
    check("read word 63", rd_q.pop_front(), 16'h1204);
    $display("test disable done");
    fifo_test();
    print_verdict();
  end

  initial begin
    // The tests need about 25,000 cycles; this limit leaves ample margin.
    #(40000 * 5);
    n_mismatch++;
    print_verdict();
  end
endmodule // serial_eeprom_command_interface_bench
